// *** tcc_timer16.sv ***
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_timer16
	import tcc_pkg::*;
#(
	parameter int FILTER_SAMPLES = `TCC_FILTER_SAMPLES
) (
	// clock, reset, freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// prescaled timer clock enable, same domain
	input wire logic timer_tick,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// trigger pins, asynchronous
	input wire logic capture_input_pin,
	input wire logic comparator_result,
	// interrupt requests and service acknowledges
	input wire logic ack_capture,
	input wire logic ack_compare_a,
	input wire logic ack_compare_b,
	output logic irq_capture,
	output logic irq_compare_a,
	output logic irq_compare_b,
	// compare outputs
	output logic compare_output_state_a,
	output logic compare_output_state_b
);

	initial begin
		if (FILTER_SAMPLES < 2 || FILTER_SAMPLES > 8) begin
			$error("tcc_timer16: FILTER_SAMPLES out of range");
		end
	end

	function automatic logic is_pwm(input tcc_mode_t m);
		is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
	endfunction
	function automatic logic is_dual(input tcc_mode_t m);
		is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
	endfunction
	function automatic logic icr_top(input tcc_mode_t m);
		icr_top = (m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he);
	endfunction
	function automatic logic [15:0] top_of(input tcc_mode_t m, input logic [15:0] oa,
			input logic [15:0] ic);
		case (m)
			4'h1, 4'h5: top_of = `TCC_TOP_8;
			4'h2, 4'h6: top_of = `TCC_TOP_9;
			4'h3, 4'h7: top_of = `TCC_TOP_10;
			4'h4, 4'h9, 4'hb, 4'hf: top_of = oa;
			4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
			default: top_of = `TCC_TOP_MAX;
		endcase
	endfunction
	// output state after a compare match (or forced match)
	function automatic logic on_match(input logic oc, input tcc_action_t com,
			input tcc_mode_t m, input logic up);
		logic r;
		r = oc;
		if (!is_pwm(m)) begin
			case (com)
				2'h1: r = !oc;
				2'h2: r = 1'b0;
				2'h3: r = 1'b1;
				default: r = oc;
			endcase
		end else if (!is_dual(m)) begin
			if (com == 2'h2) r = 1'b1;
			if (com == 2'h3) r = 1'b0;
		end else begin
			if (com == 2'h2) r = !up;
			if (com == 2'h3) r = up;
		end
		on_match = r;
	endfunction

	// ---------------- bus front end ----------------
	tcc_bus_e bus_state;
	logic [11:0] addr_q;
	logic write_q;
	logic [7:0] temp_hi;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] irq_en;
	logic comp_sel;
	logic [15:0] count;
	logic [15:0] capture_value;
	logic [15:0] cmp_buf [2];
	logic [15:0] cmp_act [2];
	logic flag_cap;
	logic [1:0] flag_cmp;
	logic [1:0] oc_state;
	wire logic access = ce && bus_state == TCC_BUS_DATA;
	wire logic wr_en = access && write_q;
	wire logic rd_en = access && !write_q;
	wire logic [7:0] wbyte = hwdata[7:0];
	wire tcc_mode_t mode = {ctrl_b[`TCC_B_WGM_HI], ctrl_a[`TCC_A_WGM_LO]};
	wire logic pwm = is_pwm(mode);
	wire logic dual = is_dual(mode);
	wire logic [15:0] top = top_of(mode, cmp_act[0], capture_value);
	wire logic count_wr = wr_en && addr_q == `TCC_ADDR_COUNT_LO;
	wire logic hi_wr = wr_en && (addr_q == `TCC_ADDR_COUNT_HI || addr_q == `TCC_ADDR_CAP_HI ||
		addr_q == `TCC_ADDR_CMPA_HI || addr_q == `TCC_ADDR_CMPB_HI);

	// one wait state: the data phase is served one clock after the address phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= TCC_BUS_ADDR;
			addr_q <= 12'h000;
			write_q <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			hresp <= 1'b0;
			if (bus_state == TCC_BUS_DATA) begin
				bus_state <= TCC_BUS_ADDR;
				hreadyout <= 1'b1;
			end else if (hsel && htrans[1] && hready) begin
				bus_state <= TCC_BUS_DATA;
				addr_q <= {haddr[11:2], 2'b00};
				write_q <= hwrite;
				hreadyout <= 1'b0;
			end
		end
	end

	// read data and the shared high byte holder
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
			temp_hi <= `TCC_RST_BYTE;
		end else if (ce) begin
			if (hi_wr) temp_hi <= wbyte;
			if (rd_en) begin
				case (addr_q)
					`TCC_ADDR_CTRL_A: hrdata <= {24'h000000, ctrl_a};
					`TCC_ADDR_CTRL_B: hrdata <= {24'h000000, ctrl_b};
					`TCC_ADDR_COUNT_LO: begin
						hrdata <= {24'h000000, count[7:0]};
						temp_hi <= count[15:8];
					end
					`TCC_ADDR_COUNT_HI: hrdata <= {24'h000000, temp_hi};
					`TCC_ADDR_CAP_LO: begin
						hrdata <= {24'h000000, capture_value[7:0]};
						temp_hi <= capture_value[15:8];
					end
					`TCC_ADDR_CAP_HI: hrdata <= {24'h000000, temp_hi};
					`TCC_ADDR_CMPA_LO: hrdata <= {24'h000000, cmp_buf[0][7:0]};
					`TCC_ADDR_CMPA_HI: hrdata <= {24'h000000, cmp_buf[0][15:8]};
					`TCC_ADDR_CMPB_LO: hrdata <= {24'h000000, cmp_buf[1][7:0]};
					`TCC_ADDR_CMPB_HI: hrdata <= {24'h000000, cmp_buf[1][15:8]};
					`TCC_ADDR_IRQ_EN: hrdata <= {24'h000000, irq_en};
					`TCC_ADDR_FLAGS: hrdata <= {26'h0000000, flag_cap, 2'b00, flag_cmp, 1'b0};
					`TCC_ADDR_COMP_CS: hrdata <= {29'h00000000, comp_sel, 2'b00};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// control registers; action bits act on the next match directly
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a <= `TCC_RST_BYTE;
			ctrl_b <= `TCC_RST_BYTE;
			irq_en <= `TCC_RST_BYTE;
			comp_sel <= 1'b0;
		end else if (wr_en) begin
			case (addr_q)
				`TCC_ADDR_CTRL_A: ctrl_a <= wbyte;
				`TCC_ADDR_CTRL_B: ctrl_b <= {wbyte[7:6], 1'b0, wbyte[4:3], 3'b000};
				`TCC_ADDR_IRQ_EN: irq_en <= {2'b00, wbyte[5], 2'b00, wbyte[2:1], 1'b0};
				`TCC_ADDR_COMP_CS: comp_sel <= wbyte[`TCC_CS_SEL];
				default: ;
			endcase
		end
	end

	// ---------------- counter ----------------
	logic count_up;
	logic match_block;
	wire logic tick = ce && timer_tick;
	wire logic top_hit = count == top && !match_block;
	wire logic at_bottom = count == `TCC_RST_WORD;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= `TCC_RST_WORD;
			count_up <= 1'b1;
		end else if (count_wr) begin
			count <= {temp_hi, wbyte};
		end else if (tick) begin
			if (dual) begin
				if (count_up && top_hit) begin
					count_up <= 1'b0;
					count <= count - 16'h0001;
				end else if (!count_up && at_bottom) begin
					count_up <= 1'b1;
					count <= count + 16'h0001;
				end else begin
					count <= count_up ? count + 16'h0001 : count - 16'h0001;
				end
			end else begin
				count_up <= 1'b1;
				count <= (mode != 4'h0 && top_hit) ? `TCC_RST_WORD : count + 16'h0001;
			end
		end
	end

	// held until a tick, so a stopped timer still loses the first match after a write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			match_block <= 1'b0;
		end else if (count_wr) begin
			match_block <= 1'b1;
		end else if (tick) begin
			match_block <= 1'b0;
		end
	end

	// ---------------- compare units ----------------
	wire logic buf_event = tick && ((mode == 4'h8 || mode == 4'h9) ? at_bottom : top_hit);
	logic [1:0] cmp_match;
	logic [1:0] force_hit;
	tcc_action_t com [2];
	assign com[0] = ctrl_a[`TCC_A_COMA];
	assign com[1] = ctrl_a[`TCC_A_COMB];
	assign cmp_match[0] = tick && !match_block && count == cmp_act[0];
	assign cmp_match[1] = tick && !match_block && count == cmp_act[1];
	assign force_hit[0] = wr_en && addr_q == `TCC_ADDR_CTRL_C && wbyte[`TCC_C_FORCE_A] && !pwm;
	assign force_hit[1] = wr_en && addr_q == `TCC_ADDR_CTRL_C && wbyte[`TCC_C_FORCE_B] && !pwm;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				cmp_buf[i] <= `TCC_RST_WORD;
				cmp_act[i] <= `TCC_RST_WORD;
			end
		end else if (ce) begin
			if (wr_en && addr_q == `TCC_ADDR_CMPA_LO) cmp_buf[0] <= {temp_hi, wbyte};
			if (wr_en && addr_q == `TCC_ADDR_CMPB_LO) cmp_buf[1] <= {temp_hi, wbyte};
			for (int i = 0; i < 2; i++) begin
				if (!pwm || buf_event) begin
					cmp_act[i] <= cmp_buf[i];
				end
			end
		end
	end

	// no mode term in reset or hold path: state survives mode changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_state <= 2'b00;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (force_hit[i] || cmp_match[i]) begin
					oc_state[i] <= on_match(oc_state[i], com[i], mode, count_up);
				end else if (pwm && !dual && top_hit && tick) begin
					if (com[i] == 2'h2) oc_state[i] <= 1'b0;
					if (com[i] == 2'h3) oc_state[i] <= 1'b1;
				end
			end
		end
	end

	// ---------------- capture path ----------------
	logic [1:0] pin_sync;
	logic [1:0] comp_sync;
	logic [FILTER_SAMPLES-2:0] samples;
	logic filt_out;
	logic edge_prev;
	wire logic trig_sel = comp_sel ? comp_sync[1] : pin_sync[1];
	wire logic filt_en = ctrl_b[`TCC_B_FILT];
	wire logic edge_src = filt_en ? filt_out : trig_sel;
	wire logic trig_live = !icr_top(mode);
	wire logic rising = ctrl_b[`TCC_B_EDGE];
	wire logic cap_event = trig_live && (rising ? (edge_src && !edge_prev) :
		(!edge_src && edge_prev));
	wire logic cap_event_ce = ce && cap_event;
	// the newest sample counts as the last of the run, so the filter adds exactly four clocks
	wire logic [FILTER_SAMPLES-1:0] window = {samples, trig_sel};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync <= 2'b00;
			comp_sync <= 2'b00;
		end else if (ce) begin
			pin_sync <= {pin_sync[0], capture_input_pin};
			comp_sync <= {comp_sync[0], comparator_result};
		end
	end
	// filter clocks on the system clock regardless of the timer prescale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samples <= '0;
			filt_out <= 1'b0;
		end else if (ce) begin
			samples <= window[FILTER_SAMPLES-2:0];
			if (&window) filt_out <= 1'b1;
			else if (~|window) filt_out <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_prev <= 1'b0;
		end else if (ce) begin
			edge_prev <= edge_src;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_value <= `TCC_RST_WORD;
		end else if (cap_event_ce) begin
			capture_value <= count;
		end else if (wr_en && addr_q == `TCC_ADDR_CAP_LO && icr_top(mode)) begin
			capture_value <= {temp_hi, wbyte};
		end
	end

	// ---------------- flags and requests; a set beats a same-cycle clear ----------------
	wire logic flag_wr = wr_en && addr_q == `TCC_ADDR_FLAGS;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_cap <= 1'b0;
			flag_cmp <= 2'b00;
		end else if (ce) begin
			if (cap_event) flag_cap <= 1'b1;
			else if (ack_capture || (flag_wr && wbyte[`TCC_F_CAP])) flag_cap <= 1'b0;
			if (cmp_match[0]) flag_cmp[0] <= 1'b1;
			else if (ack_compare_a || (flag_wr && wbyte[`TCC_F_CMPA])) flag_cmp[0] <= 1'b0;
			if (cmp_match[1]) flag_cmp[1] <= 1'b1;
			else if (ack_compare_b || (flag_wr && wbyte[`TCC_F_CMPB])) flag_cmp[1] <= 1'b0;
		end
	end

	// requests follow the flags one clock late so every output is a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_capture <= 1'b0;
			irq_compare_a <= 1'b0;
			irq_compare_b <= 1'b0;
			compare_output_state_a <= 1'b0;
			compare_output_state_b <= 1'b0;
		end else if (ce) begin
			irq_capture <= flag_cap && irq_en[`TCC_F_CAP];
			irq_compare_a <= flag_cmp[0] && irq_en[`TCC_F_CMPA];
			irq_compare_b <= flag_cmp[1] && irq_en[`TCC_F_CMPB];
			compare_output_state_a <= oc_state[0];
			compare_output_state_b <= oc_state[1];
		end
	end

endmodule

`default_nettype wire

// *** tcc_consts.svh ***
// Overview of operation
// - A qualifying edge on the chosen trigger copies the 16-bit count into capture_value.
// - capture_flag sets in the same clock the count is stored.
// - capture_flag with enable requests interrupt; cleared by service or writing one.
// - Read capture low byte first; it loads the shared high byte holder.
// - capture_value is writable only in modes using it as top; high first.
// - comparator_capture_select picks comparator_result; software clears the flag afterwards.
// - Filter output changes only after four equal consecutive samples.
// - Filter enable in timer_control_b adds four system clocks; runs on system clock.
// - Trigger path stays active except in modes using capture_value as top.
// - A new capture overwrites an unread capture_value.
// - compare_flag with enable requests interrupt; cleared by service or writing one.
// - Compare unit A can act as the counter top in the modes selecting it.
// - Compare value double buffered in PWM modes; bypassed in normal and clear-on-match.
// - CPU reaches the buffer when buffering is on, else the compare register.
// - Compare high byte reads return the stored byte, not the holder.
// - Compare high write loads holder; low write updates all 16 bits at once.
// - force_compare_strobe in non-PWM modes acts on output only, no flag, no count change.
// - A counter write suppresses every compare match at the next timer tick.
// - Writing the count equal to variable top in PWM misses top, runs to 0xffff.
// - compare_output_state keeps its value across waveform mode changes.
// - compare_output_action bits are unbuffered and take effect at once.
// - Reset clears compare_output_state to zero.
// - A CPU counter write beats a simultaneous clear or count.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register byte addresses
`define TCC_ADDR_CTRL_A 12'h000
`define TCC_ADDR_CTRL_B 12'h004
`define TCC_ADDR_CTRL_C 12'h008
`define TCC_ADDR_COUNT_LO 12'h00c
`define TCC_ADDR_COUNT_HI 12'h010
`define TCC_ADDR_CAP_LO 12'h014
`define TCC_ADDR_CAP_HI 12'h018
`define TCC_ADDR_CMPA_LO 12'h01c
`define TCC_ADDR_CMPA_HI 12'h020
`define TCC_ADDR_CMPB_LO 12'h024
`define TCC_ADDR_CMPB_HI 12'h028
`define TCC_ADDR_IRQ_EN 12'h02c
`define TCC_ADDR_FLAGS 12'h030
`define TCC_ADDR_COMP_CS 12'h034

// field positions
`define TCC_A_COMA 7:6
`define TCC_A_COMB 5:4
`define TCC_A_WGM_LO 1:0
`define TCC_B_FILT 7
`define TCC_B_EDGE 6
`define TCC_B_WGM_HI 4:3
`define TCC_C_FORCE_A 7
`define TCC_C_FORCE_B 6
`define TCC_F_CAP 5
`define TCC_F_CMPB 2
`define TCC_F_CMPA 1
`define TCC_CS_SEL 2

// reset values and fixed tops
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_TOP_MAX 16'hffff
`define TCC_TOP_8 16'h00ff
`define TCC_TOP_9 16'h01ff
`define TCC_TOP_10 16'h03ff

// timing
`define TCC_FILTER_SAMPLES 4

`endif

// *** tcc_pkg.sv ***
package tcc_pkg;
	typedef enum logic [0:0] {
		TCC_BUS_ADDR = 1'b0,
		TCC_BUS_DATA = 1'b1
	} tcc_bus_e;
	typedef logic [3:0] tcc_mode_t;
	typedef logic [1:0] tcc_action_t;
endpackage

// *** tcc_timer16_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module tcc_timer16_checker
	import tcc_pkg::*;
#(
	parameter int FILTER_SAMPLES = 4
) (
	// clock, reset, timer tick
	input wire logic clk,
	input wire logic rst_n,
	input wire logic timer_tick,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// interrupts and compare output
	input wire logic ack_capture,
	input wire logic ack_compare_a,
	input wire logic ack_compare_b,
	input wire logic irq_capture,
	input wire logic irq_compare_a,
	input wire logic irq_compare_b,
	input wire logic compare_output_state_a
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_resp_okay: assert property (hresp == 1'h0)
		else $error("bus response not okay");
	a_wait_one: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
		else $error("bus wait state not exactly one cycle");
	a_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data changed outside a transfer");
	a_rst_quiet: assert property (disable iff (1'h0) !rst_n |-> !compare_output_state_a && !irq_capture)
		else $error("outputs not cleared in reset");
	a_ack_cap: assert property (ack_capture |-> ##2 !irq_capture)
		else $error("capture request survives service");
	a_ack_cmp_a: assert property (ack_compare_a |-> ##2 !irq_compare_a)
		else $error("compare a request survives service");
	a_ack_cmp_b: assert property (ack_compare_b |-> ##2 !irq_compare_b)
		else $error("compare b request survives service");
	a_out_cause: assert property ($changed(compare_output_state_a) |->
		$past(timer_tick, 2) || !$past(hreadyout, 2))
		else $error("compare output moved without tick or write");

	c_capture: cover property ($rose(irq_capture));
	c_match: cover property ($rose(irq_compare_a));
	c_toggle: cover property ($changed(compare_output_state_a));
endmodule

bind tcc_timer16 tcc_timer16_checker #(.FILTER_SAMPLES(FILTER_SAMPLES)) u_chk (
	.clk(clk), .rst_n(rst_n), .timer_tick(timer_tick), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.ack_capture(ack_capture), .ack_compare_a(ack_compare_a),
	.ack_compare_b(ack_compare_b), .irq_capture(irq_capture),
	.irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
	.compare_output_state_a(compare_output_state_a)
);

`default_nettype wire

// *** tcc_event_src.sv ***
`timescale 1ns/100ps
`default_nettype none

module tcc_event_src (
	// system clock, for spike length
	input wire logic clk,
	// requested levels, spike request and length
	input wire logic want_pin,
	input wire logic want_cmp,
	input wire logic spike,
	input wire logic [3:0] glitch,
	// event lines
	output logic capture_input_pin,
	output logic comparator_result
);
	initial begin
		capture_input_pin = 1'h0;
		comparator_result = 1'h0;
	end
	// lines move off the clock edge, as a real asynchronous source does
	always @(want_pin) #37 capture_input_pin = want_pin;
	always @(want_cmp) #37 comparator_result = want_cmp;
	// noise: the pin leaves its level for glitch clocks, then returns
	always @(spike) begin
		#37 capture_input_pin = !want_pin;
		repeat (glitch) @(posedge clk);
		#37 capture_input_pin = want_pin;
	end
endmodule

`default_nettype wire

// *** test_timer16_capture_compare_units.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.svh"

module test_timer16_capture_compare_units
	import tcc_pkg::*;
;
	typedef struct packed {
		logic src;
		logic filt;
		logic rise;
		logic [15:0] cnt;
	} tcc_row_s;
	tcc_row_s rows [4] = '{'{1'h0, 1'h0, 1'h1, 16'h1234}, '{1'h1, 1'h0, 1'h0, 16'hfedc},
		'{1'h0, 1'h1, 1'h0, 16'h00ff}, '{1'h1, 1'h1, 1'h1, 16'h8001}};
	tcc_row_s r;
	logic clk = 1'h0;
	logic rst_n = 1'h1;
	logic timer_tick = 1'h0;
	logic hsel = 1'h0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic ack_capture = 1'h0;
	logic ack_compare_a = 1'h0;
	logic ack_compare_b = 1'h0;
	logic want_pin = 1'h0;
	logic want_cmp = 1'h0;
	logic spike = 1'h0;
	logic [3:0] glitch = 4'h0;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic hreadyout, hresp, capture_input_pin, comparator_result;
	logic irq_capture, irq_compare_a, irq_compare_b;
	logic compare_output_state_a, compare_output_state_b;
	int err_count = 0;
	int comparisons = 0;
	int lat [2];
	int n;

	always #50 clk = !clk;

	tcc_timer16 DUT (
		.clk(clk), .rst_n(rst_n), .ce(1'h1), .timer_tick(timer_tick),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.capture_input_pin(capture_input_pin), .comparator_result(comparator_result),
		.ack_capture(ack_capture), .ack_compare_a(ack_compare_a),
		.ack_compare_b(ack_compare_b), .irq_capture(irq_capture),
		.irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
		.compare_output_state_a(compare_output_state_a),
		.compare_output_state_b(compare_output_state_b)
	);

	tcc_event_src u_src (
		.clk(clk), .want_pin(want_pin), .want_cmp(want_cmp), .spike(spike),
		.glitch(glitch), .capture_input_pin(capture_input_pin),
		.comparator_result(comparator_result)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask

	// entered just after a rising edge; the watchdog bounds both waits
	task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(a, 1'h1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		xfer(a, 1'h0, 8'h00);
		chk(q, {24'h0, e});
	endtask

	task automatic wr16(input logic [11:0] lo, input logic [11:0] hi, input logic [15:0] v);
		wr(hi, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic rd16(input logic [11:0] lo, input logic [11:0] hi, input logic [15:0] e);
		rd(lo, e[7:0]);
		rd(hi, e[15:8]);
	endtask

	task automatic tick;
		timer_tick <= 1'h1;
		@(posedge clk);
		timer_tick <= 1'h0;
		idle(3);
	endtask

	task automatic shot(input logic [15:0] c);
		wr16(`TCC_ADDR_COUNT_LO, `TCC_ADDR_COUNT_HI, c);
		spike <= !spike;
		idle(15);
	endtask

	initial begin
		#(100 * 6000);
		err_count++;
		end_sim();
	end

	initial begin
		// a real falling edge at time zero, so no flop meets the first clock unknown
		rst_n <= 1'h0;
		idle(10);
		rst_n <= 1'h1;
		@(posedge clk);
		chk({28'h0, hreadyout, hresp, irq_capture, compare_output_state_a}, 32'h8);
		wr(`TCC_ADDR_IRQ_EN, 8'h26);
		rd(`TCC_ADDR_IRQ_EN, 8'h26);
		rd(12'h0fc, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			wr(`TCC_ADDR_COMP_CS, {5'h0, r.src, 2'h0});
			wr(`TCC_ADDR_CTRL_B, {r.filt, r.rise, 6'h00});
			want_pin <= !r.rise;
			want_cmp <= !r.rise;
			idle(12);
			wr16(`TCC_ADDR_COUNT_LO, `TCC_ADDR_COUNT_HI, r.cnt);
			wr(`TCC_ADDR_FLAGS, 8'h20);
			if (r.src) want_cmp <= r.rise;
			else want_pin <= r.rise;
			n = 0;
			@(posedge clk);
			while (irq_capture !== 1'h1) begin
				n++;
				@(posedge clk);
			end
			lat[r.filt] = n;
			rd16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, r.cnt);
			ack_capture <= 1'h1;
			@(posedge clk);
			ack_capture <= 1'h0;
			idle(2);
			chk({31'h0, irq_capture}, 32'h0);
		end
		chk(32'(lat[1] - lat[0]), 32'h4);
		want_pin <= 1'h0;
		wr(`TCC_ADDR_COMP_CS, 8'h00);
		glitch <= 4'h3;
		for (int f = 0; f < 2; f++) begin
			wr(`TCC_ADDR_CTRL_B, {f[0], 7'h40});
			idle(12);
			wr(`TCC_ADDR_FLAGS, 8'h20);
			spike <= !spike;
			idle(15);
			rd(`TCC_ADDR_FLAGS, f ? 8'h00 : 8'h20);
		end
		wr(`TCC_ADDR_FLAGS, 8'h20);
		wr(`TCC_ADDR_CTRL_B, 8'h18);
		wr16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, 16'h3c5a);
		rd16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, 16'h3c5a);
		shot(16'h0777);
		rd(`TCC_ADDR_FLAGS, 8'h00);
		wr(`TCC_ADDR_CTRL_B, 8'h00);
		wr16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, 16'h1111);
		rd16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, 16'h3c5a);
		shot(16'h0101);
		shot(16'h0202);
		rd16(`TCC_ADDR_CAP_LO, `TCC_ADDR_CAP_HI, 16'h0202);
		wr(`TCC_ADDR_CTRL_A, 8'h50);
		wr(`TCC_ADDR_CTRL_C, 8'hc0);
		idle(3);
		chk({28'h0, compare_output_state_b, compare_output_state_a, irq_compare_b,
			irq_compare_a}, 32'hc);
		rst_n <= 1'h0;
		idle(2);
		chk({30'h0, compare_output_state_b, compare_output_state_a}, 32'h0);
		rst_n <= 1'h1;
		@(posedge clk);
		wr(`TCC_ADDR_IRQ_EN, 8'h26);
		wr(`TCC_ADDR_CTRL_A, 8'h40);
		wr16(`TCC_ADDR_CMPA_LO, `TCC_ADDR_CMPA_HI, 16'h1a10);
		wr16(`TCC_ADDR_COUNT_LO, `TCC_ADDR_COUNT_HI, 16'h1a0e);
		rd(`TCC_ADDR_CMPA_HI, 8'h1a);
		tick();
		tick();
		chk({31'h0, irq_compare_a}, 32'h0);
		tick();
		chk({30'h0, compare_output_state_a, irq_compare_a}, 32'h3);
		wr(`TCC_ADDR_CTRL_B, 8'h08);
		idle(2);
		chk({31'h0, compare_output_state_a}, 32'h1);
		ack_compare_a <= 1'h1;
		ack_compare_b <= 1'h1;
		@(posedge clk);
		ack_compare_a <= 1'h0;
		ack_compare_b <= 1'h0;
		idle(2);
		chk({31'h0, irq_compare_a}, 32'h0);
		wr(`TCC_ADDR_CTRL_B, 8'h00);
		wr(`TCC_ADDR_CTRL_A, 8'h80);
		wr16(`TCC_ADDR_COUNT_LO, `TCC_ADDR_COUNT_HI, 16'h1a10);
		tick();
		chk({30'h0, compare_output_state_a, irq_compare_a}, 32'h2);
		wr16(`TCC_ADDR_COUNT_LO, `TCC_ADDR_COUNT_HI, 16'h1a0f);
		tick();
		tick();
		chk({30'h0, compare_output_state_a, irq_compare_a}, 32'h1);
		end_sim();
	end
endmodule

`default_nettype wire
